// ---- sfm_checker.sv ----
// Port assertions for the supply fault monitor
`timescale 1ns/100ps
module sfm_checker (
  input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, drv_uv_i, hv_uv_i,
  input wire logic        drv_good_i, mode_pin_i, pump_enable_pin_i, shutdown_policy_pin_i,
  input wire logic        fault_indicator_pin_o, fault_indicator_pin_oe_n_o, pump_run_o,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic [5:0]  switch_req_pin_i, switch_drive_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_pin_only_low: assert property (fault_indicator_pin_o == 1'b0)
    else $error("fault pin level high");
  a_ack_one_later: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  // Sync flops plus arming give a few edges of slack
  a_fault_pulls_pin: assert property ((drv_good_i && drv_uv_i)[*6] |-> !fault_indicator_pin_oe_n_o)
    else $error("fault pin not pulled");
  a_clear_releases: assert property ((!drv_uv_i && !hv_uv_i)[*6] |-> fault_indicator_pin_oe_n_o)
    else $error("fault pin not released");
  a_flag_reads_set: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 && !mode_pin_i
    && !$past(fault_indicator_pin_oe_n_o) |-> wb_dat_o[7:6] == 2'b01) else $error("flag bit wrong");
  a_shutdown_opens: assert property ((mode_pin_i && !shutdown_policy_pin_i && !fault_indicator_pin_oe_n_o)[*4]
    |-> switch_drive_o == 6'h00 && !pump_run_o) else $error("shutdown missing");
  a_report_only: assert property ((mode_pin_i && shutdown_policy_pin_i && pump_enable_pin_i)[*4]
    |-> pump_run_o && switch_drive_o == switch_req_pin_i) else $error("pins not followed");
endmodule

// ---- sfm_monitor.sv ----
// Supply fault monitor with fault pin, latched flag and shutdown policy
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
module sfm_monitor (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic        drv_uv_i,
  input  wire logic        hv_uv_i,
  input  wire logic        drv_good_i,
  input  wire logic        hv_good_i,
  input  wire logic        mode_pin_i,
  input  wire logic        pump_enable_pin_i,
  input  wire logic        shutdown_policy_pin_i,
  input  wire logic [5:0]  switch_req_pin_i,
  output logic             fault_indicator_pin_o,
  output logic             fault_indicator_pin_oe_n_o,
  output logic             pump_run_o,
  output logic [5:0]       switch_drive_o,
  output logic             sleep_o,
  output logic             irq_o
);
  import sfm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers: first stage feeds only the second
  // Mode and switch pins come from outside too, so they share the two stages
  logic [12:0] s1_reg, s1_next, s2_reg, s2_next;
  always_comb begin
    s1_next = {switch_req_pin_i, mode_pin_i, shutdown_policy_pin_i, pump_enable_pin_i, hv_good_i, drv_good_i,
               hv_uv_i, drv_uv_i};
    s2_next = s1_reg;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= 13'h0000;
      s2_reg <= 13'h0000;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
    end
  end
  logic drv_uv_s, hv_uv_s, drv_good_s, hv_good_s, pump_pin_s, policy_pin_s;
  assign drv_uv_s     = s2_reg[0];
  assign hv_uv_s      = s2_reg[1];
  assign drv_good_s   = s2_reg[2];
  assign hv_good_s    = s2_reg[3];
  assign pump_pin_s   = s2_reg[4];
  assign policy_pin_s = s2_reg[5];

  ////////////////////////////////////////////////////////////////////////////
  // Registers and fault state
  logic [7:0] ctrl_reg, ctrl_next, state_reg, state_next;
  logic [1:0] ist_reg, ist_next, imask_reg, imask_next;
  logic       drv_arm_reg, drv_arm_next, hv_arm_reg, hv_arm_next;
  logic       shut_reg, shut_next, pump_q_reg, pump_q_next;
  logic       ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic       parallel, pump_en, policy_off, hv_dis, fault_now, fault_prev_reg;
  logic       wr, rd, restart;

  // Mode select and source of settings
  assign parallel   = s2_reg[6];
  assign pump_en    = parallel ? pump_pin_s : ctrl_reg[SFM_PUMP_EN_BIT];
  assign policy_off = parallel ? policy_pin_s : ctrl_reg[SFM_POLICY_BIT];
  assign hv_dis     = parallel ? ~pump_pin_s : ctrl_reg[SFM_HV_DIS_BIT];
  // Each supply arms itself; either one alone can fault
  assign fault_now  = (drv_arm_reg & drv_uv_s) | (hv_arm_reg & ~hv_dis & hv_uv_s);
  assign restart    = pump_en & ~pump_q_reg;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg;
  assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_reg;

  always_comb begin
    ctrl_next    = ctrl_reg;
    state_next   = state_reg;
    ist_next     = ist_reg;
    imask_next   = imask_reg;
    drv_arm_next = drv_arm_reg | drv_good_s;
    hv_arm_next  = hv_arm_reg | hv_good_s;
    shut_next    = shut_reg;
    pump_q_next  = pump_en;
    ack_next     = wb_cyc_i & wb_stb_i & ~ack_reg;
    rdat_next    = 32'h0000_0000;
    if (wr && wb_sel_i[0]) begin
      case (wb_adr_i)
        SFM_CTRL_OFF: begin
          ctrl_next = {1'b0, ctrl_reg[SFM_FAULT_BIT] & wb_dat_i[SFM_FAULT_BIT], wb_dat_i[5:0]};
        end
        SFM_STATE_OFF:    state_next = {2'b00, wb_dat_i[5:0]};
        SFM_IRQ_MASK_OFF: imask_next = wb_dat_i[1:0];
        default:          ;
      endcase
    end
    if (rd) begin
      case (wb_adr_i)
        SFM_CTRL_OFF:     rdat_next = {24'h000000, ctrl_reg};
        SFM_STATE_OFF:    rdat_next = {24'h000000, state_reg};
        SFM_IRQ_STAT_OFF: rdat_next = {30'h00000000, ist_reg};
        SFM_IRQ_MASK_OFF: rdat_next = {30'h00000000, imask_reg};
        default:          rdat_next = 32'h0000_0000;
      endcase
      if (wb_adr_i == SFM_IRQ_STAT_OFF) begin
        ist_next = 2'h0;
      end
    end
    // Clear before set so a fault in the write cycle survives
    if (fault_now) begin
      ctrl_next[SFM_FAULT_BIT] = 1'b1;
    end
    if (fault_now && !fault_prev_reg) begin
      ist_next[SFM_IRQ_FAULT] = 1'b1;
    end
    if (!fault_now && fault_prev_reg) begin
      ist_next[SFM_IRQ_CLEAR] = 1'b1;
    end
    if (restart) begin
      shut_next = 1'b0;
    end
    if (fault_now && !policy_off) begin
      shut_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg       <= SFM_CTRL_RST;
      state_reg      <= SFM_STATE_RST;
      ist_reg        <= SFM_IRQ_RST;
      imask_reg      <= SFM_IRQ_RST;
      drv_arm_reg    <= 1'b0;
      hv_arm_reg     <= 1'b0;
      shut_reg       <= 1'b0;
      pump_q_reg     <= 1'b0;
      ack_reg        <= 1'b0;
      rdat_reg       <= 32'h0000_0000;
      fault_prev_reg <= 1'b0;
    end else begin
      ctrl_reg       <= ctrl_next;
      state_reg      <= state_next;
      ist_reg        <= ist_next;
      imask_reg      <= imask_next;
      drv_arm_reg    <= drv_arm_next;
      hv_arm_reg     <= hv_arm_next;
      shut_reg       <= shut_next;
      pump_q_reg     <= pump_q_next;
      ack_reg        <= ack_next;
      rdat_reg       <= rdat_next;
      fault_prev_reg <= fault_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  logic [5:0] sw_req;
  assign sw_req = parallel ? s2_reg[12:7] : state_reg[5:0];
  // Pin data is always low; only the enable moves
  assign fault_indicator_pin_o      = 1'b0;
  assign fault_indicator_pin_oe_n_o = ~fault_prev_reg;
  // Switch decode is outside this block; requests pass through undecoded unless shut_reg forces all six off
  assign pump_run_o     = pump_en & ~shut_reg;
  assign switch_drive_o = shut_reg ? 6'h00 : sw_req;
  assign sleep_o        = ~parallel & ctrl_reg[SFM_SLEEP_BIT];
  assign irq_o          = |(ist_reg & imask_reg);
  assign wb_ack_o       = ack_reg;
  assign wb_dat_o       = rdat_reg;
endmodule

// ---- sfm_pkg.sv ----
// Package of constants for the supply fault monitor
package sfm_pkg;
  localparam logic [3:0] SFM_CTRL_OFF   = 4'h0;
  localparam logic [3:0] SFM_STATE_OFF  = 4'h4;
  localparam logic [3:0] SFM_IRQ_STAT_OFF = 4'h8;
  localparam logic [3:0] SFM_IRQ_MASK_OFF = 4'hc;
  localparam int SFM_PUMP_EN_BIT  = 1;
  localparam int SFM_HV_DIS_BIT   = 3;
  localparam int SFM_POLICY_BIT   = 4;
  localparam int SFM_SLEEP_BIT    = 5;
  localparam int SFM_FAULT_BIT    = 6;
  localparam logic [7:0] SFM_CTRL_RST  = 8'h00;
  localparam logic [7:0] SFM_STATE_RST = 8'h00;
  localparam logic [1:0] SFM_IRQ_RST   = 2'h0;
  localparam int SFM_IRQ_FAULT = 0;
  localparam int SFM_IRQ_CLEAR = 1;
  localparam int SFM_SYNC_STAGES = 2;
endpackage

// ---- sfm_supply_model.sv ----
// Supply comparator model on the far side of the monitor
`timescale 1ns/100ps
module sfm_supply_model (
  input  wire logic drv_low_i,
  input  wire logic hv_low_i,
  input  wire logic power_i,
  output logic      drv_uv_o,
  output logic      hv_uv_o,
  output logic      drv_good_o,
  output logic      hv_good_o
);
  // Comparators are raw levels; good simply follows power_i
  assign drv_uv_o   = drv_low_i;
  assign hv_uv_o    = hv_low_i;
  assign drv_good_o = power_i;
  assign hv_good_o  = power_i;
endmodule

// ---- tb_supply_fault_monitor_logic.sv ----
// Self-checking bench for the supply fault monitor
`timescale 1ns/100ps
module tb_supply_fault_monitor_logic;
  import sfm_pkg::*;
  logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, mode_pin_i, pump_enable_pin_i;
  logic        shutdown_policy_pin_i, drv_uv_i, hv_uv_i, drv_good_i, hv_good_i, fault_indicator_pin_o;
  logic        fault_indicator_pin_oe_n_o, pump_run_o, sleep_o, irq_o, drv_low, hv_low, powered;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, expq[$];
  logic [5:0]  switch_req_pin_i, switch_drive_o, st;
  int          n_errors, compares;
  sfm_monitor dut (.*);
  sfm_supply_model sup (.drv_low_i(drv_low), .hv_low_i(hv_low), .power_i(powered), .drv_uv_o(drv_uv_i),
    .hv_uv_o(hv_uv_i), .drv_good_o(drv_good_i), .hv_good_o(hv_good_i));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // For a read, d is the value the read must return
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    if (!w)
      expq.push_back(d);
    {wb_adr_i, wb_we_i, wb_dat_i, wb_cyc_i, wb_stb_i} <= {a, w, d, 2'b11};
    n = 0;
    // Ack is looked at between edges so its own update cannot race the test
    do begin
      @(negedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      report_and_stop();
    end
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic wait_oe(input logic exp);
    int n;
    for (n = 0; fault_indicator_pin_oe_n_o !== exp && n < 20; n++)
      @(posedge clk_i);
    check("fault pin enable", 32'(fault_indicator_pin_oe_n_o), 32'(exp));
    repeat (2) @(posedge clk_i);
  endtask
  always @(negedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0)
      check("read data", wb_dat_o, expq.pop_front());
  initial begin
    void'($urandom(32'h5d86));
    {rst_i, wb_we_i, wb_cyc_i, wb_stb_i, mode_pin_i, pump_enable_pin_i, shutdown_policy_pin_i} = 7'h40;
    {drv_low, hv_low, powered, wb_adr_i, wb_sel_i, wb_dat_i, switch_req_pin_i} = {11'h00f, 38'h0};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(SFM_CTRL_OFF, 1'b0, 32'h0);
    wb(SFM_STATE_OFF, 1'b0, 32'h0);
    wb(4'h1, 1'b0, 32'h0);
    drv_low <= 1'b1;
    repeat (8) @(posedge clk_i);
    wait_oe(1'b1);
    {drv_low, powered} <= 2'b01;
    st = 6'($urandom);
    wb(SFM_IRQ_MASK_OFF, 1'b1, 32'h3);
    wb(SFM_STATE_OFF, 1'b1, 32'(st));
    wb(SFM_CTRL_OFF, 1'b1, 32'h02);
    check("pump, switches", 32'({pump_run_o, switch_drive_o}), 32'({1'b1, st}));
    hv_low <= 1'b1;
    wait_oe(1'b0);
    check("shutdown, irq", 32'({pump_run_o, switch_drive_o, irq_o}), 32'h1);
    wb(SFM_CTRL_OFF, 1'b0, 32'h42);
    wb(SFM_IRQ_STAT_OFF, 1'b0, 32'h1);
    check("irq after read", 32'(irq_o), 32'h0);
    hv_low <= 1'b0;
    wait_oe(1'b1);
    wb(SFM_CTRL_OFF, 1'b0, 32'h42);
    wb(SFM_CTRL_OFF, 1'b1, 32'h02);
    wb(SFM_CTRL_OFF, 1'b0, 32'h02);
    check("still shut", 32'({pump_run_o, switch_drive_o}), 32'h0);
    wb(SFM_CTRL_OFF, 1'b1, 32'h00);
    wb(SFM_CTRL_OFF, 1'b1, 32'h02);
    check("restart", 32'({pump_run_o, switch_drive_o}), 32'({1'b1, st}));
    wb(SFM_CTRL_OFF, 1'b1, 32'h0a);
    hv_low <= 1'b1;
    repeat (8) @(posedge clk_i);
    wait_oe(1'b1);
    wb(SFM_CTRL_OFF, 1'b1, 32'h12);
    wait_oe(1'b0);
    check("report only", 32'({pump_run_o, switch_drive_o}), 32'({1'b1, st}));
    {drv_low, hv_low} <= 2'b10;
    repeat (8) @(posedge clk_i);
    wait_oe(1'b0);
    drv_low <= 1'b0;
    wait_oe(1'b1);
    wb(SFM_CTRL_OFF, 1'b1, 32'h32);
    check("sleep on", 32'(sleep_o), 32'h1);
    {mode_pin_i, pump_enable_pin_i, shutdown_policy_pin_i, switch_req_pin_i} <= {3'b111, 6'($urandom)};
    repeat (6) @(posedge clk_i);
    check("pass through", 32'(switch_drive_o), 32'(switch_req_pin_i));
    check("sleep in pin mode", 32'(sleep_o), 32'h0);
    shutdown_policy_pin_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    drv_low <= 1'b1;
    wait_oe(1'b0);
    check("pin shutdown", 32'({pump_run_o, switch_drive_o}), 32'h0);
    report_and_stop();
  end
endmodule
bind sfm_monitor sfm_checker chk (.*);
